// [switch_fault_status_readout.sv]
// Serial readout of switch states and fault flags, with pipelined replies.
// Assumes a serial master driving sclk, cs_n and mosi; resetn is power-on.
//
// How it works
// - Frame is address, read bit, 24 data
// - Address 1E returns twelve programmable inputs
// - Address 1F returns twenty-one ground inputs
// - Closed switch reads one, open zero
// - Reply comes in the frame after command
// - Unused status data bits read zero
// - Bit 23 is OR of fault flags, zero in fault reply
// - Bit 22 is the interrupt flag
// - Power-on sets summary and interrupt flag
// - First frame returns ground word, clears interrupt
// - Fault read clears power-on and other flags
// - Fault flags come back after next command
// - Fault register bit layout is fixed
// - Bad frame sets serial error flag
// - Condition flags clear only after condition ends
`timescale 1ns/1ps
module switch_fault_status_readout
  import switch_readout_pkg::*;
#(
  parameter int N_PROG = N_PROG_DOC,
  parameter int N_GND = N_GND_DOC
) (
  // System clock and power-on reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Switch inputs, high when closed
  input wire logic [N_PROG-1:0] programmable_input,
  input wire logic [N_GND-1:0] ground_switch_input,
  // Supply, thermal and hash mismatch conditions
  input wire logic undervoltage,
  input wire logic overvoltage,
  input wire logic temperature_warning,
  input wire logic overtemperature,
  input wire logic hash_mismatch,
  // Wake events, rising edge counts
  input wire logic int_pin_wake,
  input wire logic wake_pin_wake,
  input wire logic spi_wake
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  generate
    if (N_PROG < 1 || N_PROG > DATA_LOW_W || N_GND < 1 || N_GND > DATA_LOW_W) begin : g_bad
      $error("switch counts must lie between 1 and 22");
    end
  endgenerate

  localparam int N_SYNC = 1 + N_PROG + N_GND + 8;
  localparam logic [N_SYNC-1:0] SYNC_RESET = {1'b1, {(N_SYNC - 1){1'b0}}};

  // ****************************************
  // State types
  // ****************************************
  typedef struct packed {
    logic cs_prev;
    logic clr;
    logic miso_oe;
    logic por_pending;
    logic [31:0] tx_word;
    logic [N_PROG-1:0] prog_prev;
    logic [N_GND-1:0] gnd_prev;
    logic [2:0] wake_prev;
    logic [N_FAULT-1:0] fault_prev;
  } sys_state_t;

  typedef struct packed {
    logic [5:0] count;
    logic miso;
  } link_state_t;

  typedef struct packed {
    logic [31:0] word;
  } rx_state_t;

  sys_state_t state;
  sys_state_t next_state;
  link_state_t link;
  link_state_t next_link;
  rx_state_t rx;
  rx_state_t next_rx;

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [N_SYNC-1:0] sync_in;
  logic [N_SYNC-1:0] sync_q;
  logic cs_sync;
  logic [N_PROG-1:0] prog_sync;
  logic [N_GND-1:0] gnd_sync;
  logic uv_sync;
  logic ov_sync;
  logic temp_sync;
  logic ot_sync;
  logic hash_sync;
  logic [2:0] wake_sync;

  assign sync_in = {cs_n, programmable_input, ground_switch_input,
                    undervoltage, overvoltage, temperature_warning,
                    overtemperature, hash_mismatch,
                    int_pin_wake, wake_pin_wake, spi_wake};

  // Chip select idles high so a reset does not look like a frame end
  sync_bits #(
    .WIDTH(N_SYNC),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .clk(clk_sys),
    .resetn(resetn),
    .async_in(sync_in),
    .sync_out(sync_q)
  );

  assign {cs_sync, prog_sync, gnd_sync, uv_sync, ov_sync, temp_sync,
          ot_sync, hash_sync, wake_sync} = sync_q;

  // ****************************************
  // Link domain: shift in and out
  // ****************************************
  logic link_resetn;

  // Counter is cleared by the system side after each frame end;
  // clr comes from a flip-flop, so the combined reset is glitch free
  assign link_resetn = resetn & ~state.clr;

  // Reply bits leave on the rising edge, MSB first; tx_word is held
  // still by the system side for the whole frame
  always_comb begin
    next_link = link;
    if (link.count != CNT_SAT) begin
      next_link.count = link.count + 6'h01;
    end
    if (link.count[5]) begin
      next_link.miso = 1'b0;
    end else begin
      next_link.miso = state.tx_word[~link.count[4:0]];
    end
  end

  always_ff @(posedge sclk or negedge link_resetn) begin
    if (!link_resetn) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // Command bits are taken on the falling edge
  always_comb begin
    next_rx.word = {rx.word[FRAME_BITS-2:0], mosi};
  end

  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  assign miso = link.miso;

  // ****************************************
  // Frame decode
  // ****************************************
  logic frame_end;
  logic frame_ok;
  logic [6:0] cmd_addr;
  logic cmd_rw;
  logic addr_known;
  logic serial_err;
  logic good_frame;
  logic fault_read;
  logic first_frame;

  // Count and received word are quiet by the time cs_n is seen high
  // here, because sclk has stopped; they are sampled as static words
  assign frame_end = cs_sync & ~state.cs_prev;
  assign frame_ok = (link.count == CNT_FULL);
  assign cmd_addr = rx.word[ADDR_MSB:ADDR_LSB];
  assign cmd_rw = rx.word[RW_BIT];
  assign addr_known = (cmd_rw == RW_READ) &&
                      (cmd_addr == ADDR_PROG || cmd_addr == ADDR_GND ||
                       cmd_addr == ADDR_FAULT);
  assign serial_err = frame_end & (~frame_ok | ~addr_known);
  assign good_frame = frame_end & frame_ok;
  assign fault_read = good_frame & addr_known & (cmd_addr == ADDR_FAULT);
  assign first_frame = good_frame & state.por_pending;

  // ****************************************
  // Fault flags
  // ****************************************
  logic [N_FAULT-1:0] fault_set;
  logic [N_FAULT-1:0] fault_cond;
  logic [N_FAULT-1:0] fault_flags;
  logic [2:0] wake_rise;

  assign wake_rise = wake_sync & ~state.wake_prev;

  always_comb begin
    fault_set = '0;
    fault_cond = '0;
    fault_set[F_SERIAL] = serial_err;
    fault_cond[F_SERIAL] = serial_err;
    fault_set[F_HASH] = hash_sync;
    fault_cond[F_HASH] = hash_sync;
    fault_set[F_UV] = uv_sync;
    fault_cond[F_UV] = uv_sync;
    fault_set[F_OV] = ov_sync;
    fault_cond[F_OV] = ov_sync;
    fault_set[F_TEMP] = temp_sync;
    fault_cond[F_TEMP] = temp_sync;
    fault_set[F_OT] = ot_sync;
    fault_cond[F_OT] = ot_sync;
    fault_set[F_INT_WAKE:F_SPI_WAKE] = wake_rise;
  end

  generate
    for (genvar i = 0; i < N_FAULT; i++) begin : g_fault
      if (i == F_GAP) begin : g_gap
        assign fault_flags[i] = 1'b0;
      end else begin : g_flag
        sticky_flag #(
          .RESET_VAL(FAULT_RESET[i])
        ) u_flag (
          .clk(clk_sys),
          .resetn(resetn),
          .set(fault_set[i]),
          .cond(fault_cond[i]),
          .clear(fault_read),
          .flag(fault_flags[i])
        );
      end
    end
  endgenerate

  // ****************************************
  // Interrupt flag and fault summary
  // ****************************************
  logic int_event;
  logic int_flag;
  logic fault_sum;

  assign int_event = (prog_sync != state.prog_prev) ||
                     (gnd_sync != state.gnd_prev) ||
                     ((fault_flags & ~state.fault_prev) != '0);

  // Sets on reset, so power-on is reported until the first frame
  sticky_flag #(
    .RESET_VAL(INT_RESET)
  ) u_int_flag (
    .clk(clk_sys),
    .resetn(resetn),
    .set(int_event),
    .cond(1'b0),
    .clear(fault_read | first_frame),
    .flag(int_flag)
  );

  assign fault_sum = |fault_flags;

  // ****************************************
  // Reply words
  // ****************************************
  logic [31:0] prog_word;
  logic [31:0] gnd_word;
  logic [31:0] fault_word;
  logic [31:0] echo_word;
  logic [31:0] por_word;

  // Summary and interrupt bits are snapshots taken at decode; an error
  // raised by the frame being decoded shows from the following reply on
  always_comb begin
    prog_word = {cmd_addr, cmd_rw, fault_sum, int_flag,
                 {(DATA_LOW_W - N_PROG){1'b0}}, prog_sync};
    gnd_word = {cmd_addr, cmd_rw, fault_sum, int_flag,
                {(DATA_LOW_W - N_GND){1'b0}}, gnd_sync};
    fault_word = {cmd_addr, cmd_rw, 1'b0, int_flag,
                  {(DATA_LOW_W - N_FAULT){1'b0}}, fault_flags};
    echo_word = {cmd_addr, cmd_rw, fault_sum, int_flag, {DATA_LOW_W{1'b0}}};
    por_word = {ADDR_GND, RW_READ, fault_sum, int_flag,
                {(DATA_LOW_W - N_GND){1'b0}}, gnd_sync};
  end

  // ****************************************
  // System domain sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.cs_prev = cs_sync;
    next_state.clr = frame_end;
    next_state.miso_oe = ~cs_sync;
    next_state.prog_prev = prog_sync;
    next_state.gnd_prev = gnd_sync;
    next_state.wake_prev = wake_sync;
    next_state.fault_prev = fault_flags;
    if (good_frame) begin
      next_state.por_pending = 1'b0;
      // The reply to this command is shifted out in the next frame
      case (cmd_addr)
        ADDR_PROG: next_state.tx_word = addr_known ? prog_word : echo_word;
        ADDR_GND: next_state.tx_word = addr_known ? gnd_word : echo_word;
        ADDR_FAULT: next_state.tx_word = addr_known ? fault_word : echo_word;
        default: next_state.tx_word = echo_word;
      endcase
    end else if (state.por_pending && cs_sync && state.cs_prev) begin
      // Kept live while idle; frozen once a frame has started
      next_state.tx_word = por_word;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state.cs_prev <= 1'b1;
      state.clr <= 1'b0;
      state.miso_oe <= 1'b0;
      state.por_pending <= 1'b1;
      state.tx_word <= WORD_RESET;
      state.prog_prev <= '0;
      state.gnd_prev <= '0;
      state.wake_prev <= '0;
      state.fault_prev <= FAULT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign miso_oe = state.miso_oe;

endmodule

// [switch_readout_pkg.sv]
// Shared constants for the switch and fault status readout.
// Assumes a 32-bit serial frame with the device as serial slave.
package switch_readout_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 32;
  localparam int ADDR_MSB = 31;
  localparam int ADDR_LSB = 25;
  localparam int RW_BIT = 24;
  localparam int SUM_BIT = 23;
  localparam int INT_BIT = 22;
  localparam int DATA_LOW_W = 22;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h3F;
  localparam logic RW_READ = 1'h0;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [6:0] ADDR_PROG = 7'h1E;
  localparam logic [6:0] ADDR_GND = 7'h1F;
  localparam logic [6:0] ADDR_FAULT = 7'h21;

  // ****************************************
  // Input counts and fault register fields
  // ****************************************
  localparam int N_PROG_DOC = 12;
  localparam int N_GND_DOC = 21;
  localparam int N_FAULT = 11;
  localparam int F_SERIAL = 10;
  localparam int F_HASH = 9;
  localparam int F_GAP = 8;
  localparam int F_UV = 7;
  localparam int F_OV = 6;
  localparam int F_TEMP = 5;
  localparam int F_OT = 4;
  localparam int F_INT_WAKE = 3;
  localparam int F_PIN_WAKE = 2;
  localparam int F_SPI_WAKE = 1;
  localparam int F_POR = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [10:0] FAULT_RESET = 11'h001;
  localparam logic INT_RESET = 1'h1;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

endpackage

// [sync_bits.sv]
// Two-stage synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; no word coherence is implied.
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // The first stage feeds only the second stage
  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= {RESET_VAL, RESET_VAL};
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule

// [sticky_flag.sv]
// One sticky status flag: set by an event, cleared by a read.
// Assumes set, cond and clear are all on the same clock.
`timescale 1ns/1ps
module sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic set,
  input wire logic cond,
  input wire logic clear,
  // Flag
  output logic flag
);

  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;

  // A clear only succeeds once the underlying condition has ended;
  // an event in the clearing cycle wins so it is never lost
  always_comb begin
    next_state = state;
    if (clear && !cond) begin
      next_state.flag = 1'b0;
    end
    if (set) begin
      next_state.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state.flag <= RESET_VAL;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

endmodule

// [switch_readout_checker.sv]
// Concurrent checks on the serial side of the switch readout.
// Assumes the serial master keeps the select and clock spacing of the link.
`timescale 1ns/1ps
module switch_readout_checker
  import switch_readout_pkg::*;
#(
  parameter int N_PROG = N_PROG_DOC,
  parameter int N_GND = N_GND_DOC
) (
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sclk,
  // Serial link
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe
);
  // ****************************************
  // Output enable against chip select
  // ****************************************
  a_oe_on_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(cs_n) |-> ##[1:4] miso_oe) else $error("miso_oe late after select");
  a_oe_off_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(cs_n) |-> ##[1:4] !miso_oe) else $error("miso_oe late after release");
  a_oe_idle_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    cs_n [*5] |-> !miso_oe) else $error("miso driven while idle");
  a_oe_frame_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!cs_n) [*5] |-> miso_oe) else $error("miso not driven in frame");
  a_miso_idle_still: assert property (@(posedge clk_sys) disable iff (!resetn)
    cs_n [*6] |-> $stable(miso)) else $error("miso moved while idle");
  a_quiet_at_por: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(resetn) |-> !miso_oe && !miso) else $error("link not quiet after reset");
  // Link clock domain: the reply must already be on the wire at each shift edge and each sample edge
  a_link_rise_driven: assert property (@(posedge sclk) disable iff (!resetn)
    !cs_n |-> miso_oe) else $error("miso undriven at shift edge");
  a_link_fall_driven: assert property (@(negedge sclk) disable iff (!resetn)
    !cs_n |-> miso_oe) else $error("miso undriven at sample edge");
  c_frame_start: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(cs_n));
  c_oe_rise: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(miso_oe));
  c_reply_one: cover property (@(negedge sclk) disable iff (!resetn) miso);
endmodule
bind switch_fault_status_readout switch_readout_checker #(
  .N_PROG(N_PROG),
  .N_GND(N_GND)
) chk_i (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .sclk(sclk),
  .cs_n(cs_n),
  .miso(miso),
  .miso_oe(miso_oe)
);

// [spi_master_model.sv]
// Serial master model: frames commands MSB first and collects the reply.
// Assumes the link clock runs only inside frames, 64 ns period.
`timescale 1ns/1ps
module spi_master_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Undriven miso reads as unknown, so a missing enable never passes
  task xfer(input logic [31:0] cmd, input int n, output logic [31:0] rep);
    rep = 32'h0000_0000;
    // Select moves on even nanoseconds, clear of the system clock's rising edges
    #2;
    cs_n = 1'b0;
    #50;
    for (int i = 0; i < n; i++) begin
      mosi = cmd[31-i];
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
      rep = {rep[30:0], (miso_oe ? miso : 1'bx)};
      #32;
    end
    #20;
    cs_n = 1'b1;
    mosi = ~mosi;
    #80;
  endtask
endmodule

// [test_switch_fault_status_readout.sv]
// Self-checking bench: command sequences with expected pipelined replies.
// Assumes default input counts of twelve and twenty-one switches.
`timescale 1ns/1ps
module test_switch_fault_status_readout;
  import switch_readout_pkg::*;
  localparam logic [31:0] M_ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] M_NOINT = 32'hFFBF_FFFF;
  logic clk_sys, resetn, sclk, cs_n, mosi, miso, miso_oe, hash;
  logic [11:0] prog;
  logic [20:0] gnd;
  logic [3:0] conds;
  logic [2:0] wakes;
  logic [31:0] bad;
  int miscompares, n_compared;

  switch_fault_status_readout uut (
    .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .programmable_input(prog), .ground_switch_input(gnd),
    .undervoltage(conds[3]), .overvoltage(conds[2]), .temperature_warning(conds[1]),
    .overtemperature(conds[0]), .hash_mismatch(hash), .int_pin_wake(wakes[2]),
    .wake_pin_wake(wakes[1]), .spi_wake(wakes[0]));
  spi_master_model mcu (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] cw(input logic [6:0] a);
    return {a, RW_READ, 24'h00_0000};
  endfunction
  function automatic logic [31:0] st(input logic [6:0] a, input logic s, input logic i,
                                     input logic [21:0] d);
    return {a, RW_READ, s, i, d};
  endfunction
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Interrupt bit is masked where its clearing moment is left open
  task fr(input logic [31:0] cmd, input logic [31:0] exp, input logic [31:0] msk);
    logic [31:0] got;
    mcu.xfer(cmd, 32, got);
    chk("reply", exp & msk, got & msk);
  endtask
  task settle;
    repeat (4) @(negedge clk_sys);
  endtask
  task wrap_up;
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    miscompares = 0;
    n_compared = 0;
    resetn = 1'b0;
    prog = 12'hA53;
    gnd = 21'h15A5C3;
    conds = 4'h0;
    hash = 1'b0;
    wakes = 3'h0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (6) @(negedge clk_sys);
    // Power-on sequence
    fr(cw(ADDR_PROG), st(ADDR_GND, 1'b1, 1'b1, {1'b0, gnd}), M_ALL);
    fr(cw(ADDR_GND), st(ADDR_PROG, 1'b1, 1'b0, {10'h000, prog}), M_NOINT);
    fr(cw(ADDR_FAULT), st(ADDR_GND, 1'b1, 1'b0, {1'b0, gnd}), M_ALL);
    fr(cw(ADDR_PROG), st(ADDR_FAULT, 1'b0, 1'b0, 22'h000001), M_ALL);
    fr(cw(ADDR_GND), st(ADDR_PROG, 1'b0, 1'b0, {10'h000, prog}), M_ALL);
    // Switch changes
    @(negedge clk_sys);
    prog = 12'h5AC;
    gnd = 21'h0A5A3C;
    settle();
    fr(cw(ADDR_GND), st(ADDR_GND, 1'b0, 1'b0, {1'b0, 21'h15A5C3}), M_ALL);
    fr(cw(ADDR_PROG), st(ADDR_GND, 1'b0, 1'b1, {1'b0, gnd}), M_ALL);
    fr(cw(ADDR_GND), st(ADDR_PROG, 1'b0, 1'b0, {10'h000, prog}), M_NOINT);
    // Conditions and wake events
    @(negedge clk_sys);
    conds = 4'hF;
    hash = 1'b1;
    wakes = 3'h7;
    settle();
    wakes = 3'h0;
    settle();
    fr(cw(ADDR_GND), st(ADDR_GND, 1'b0, 1'b0, {1'b0, gnd}), M_NOINT);
    fr(cw(ADDR_FAULT), st(ADDR_GND, 1'b1, 1'b0, {1'b0, gnd}), M_NOINT);
    fr(cw(ADDR_FAULT), st(ADDR_FAULT, 1'b0, 1'b0, 22'h0002FE), M_NOINT);
    fr(cw(ADDR_FAULT), st(ADDR_FAULT, 1'b0, 1'b0, 22'h0002F0), M_NOINT);
    @(negedge clk_sys);
    conds = 4'h0;
    hash = 1'b0;
    settle();
    fr(cw(ADDR_FAULT), st(ADDR_FAULT, 1'b0, 1'b0, 22'h0002F0), M_NOINT);
    // The read that clears still reports the flags as they stood
    fr(cw(ADDR_FAULT), st(ADDR_FAULT, 1'b0, 1'b0, 22'h0002F0), M_NOINT);
    fr(cw(ADDR_GND), st(ADDR_FAULT, 1'b0, 1'b0, 22'h000000), M_NOINT);
    fr(cw(ADDR_GND), st(ADDR_GND, 1'b0, 1'b0, {1'b0, gnd}), M_NOINT);
    // Malformed frames
    mcu.xfer(cw(ADDR_PROG), 16, bad);
    fr(cw(ADDR_FAULT), st(ADDR_GND, 1'b0, 1'b0, {1'b0, gnd}), M_NOINT);
    fr(cw(ADDR_GND), st(ADDR_FAULT, 1'b0, 1'b0, 22'h000400), M_NOINT);
    for (int k = 0; k < 2; k++) begin
      bad = (k == 0) ? {7'h10, RW_READ, 24'h00_0000} : {ADDR_PROG, 1'b1, 24'h00_0000};
      fr(bad, st(ADDR_GND, 1'b0, 1'b0, {1'b0, gnd}), M_NOINT);
      // Summary is taken at decode, before this frame's own error is flagged
      fr(cw(ADDR_FAULT), {bad[31:24], 1'b0, 1'b0, 22'h000000}, M_NOINT);
      fr(cw(ADDR_GND), st(ADDR_FAULT, 1'b0, 1'b0, 22'h000400), M_NOINT);
    end
    wrap_up();
  end
endmodule
